// File: rtl/dual_timer_pkg.sv
// Package for the dual timer/counter: mode codes, bit positions, timing constants and carrier structs.
// Assumes the CPU clock is the block clock and that software registers live outside this block.
package dual_timer_pkg;

  localparam int unsigned CPU_CLKS_PER_MC      = 6;
  localparam int unsigned CPU_CLKS_PER_MC_SLOW = 12;

  localparam logic [1:0] MODE_13BIT  = 2'h0;
  localparam logic [1:0] MODE_16BIT  = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT  = 2'h3;

  // Timer mode register layout, timer 1 in the high nibble.
  localparam int unsigned GATE1_BIT    = 7;
  localparam int unsigned CTSEL1_BIT   = 6;
  localparam int unsigned MODE1_HI_BIT = 5;
  localparam int unsigned MODE1_LO_BIT = 4;
  localparam int unsigned GATE0_BIT    = 3;
  localparam int unsigned CTSEL0_BIT   = 2;
  localparam int unsigned MODE0_HI_BIT = 1;
  localparam int unsigned MODE0_LO_BIT = 0;

  localparam logic [7:0] BYTE_ZERO  = 8'h00;
  localparam logic [7:0] BYTE_ONES  = 8'hFF;
  localparam logic [4:0] LOW13_ONES = 5'h1F;
  localparam logic [4:0] LOW13_ZERO = 5'h00;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } count_pair_t;

  typedef struct packed {
    logic       write_high;
    logic       write_low;
    logic [7:0] data;
  } count_write_t;

endpackage

// File: rtl/mc_edge_sampler.sv
// Pin sampler: two-flop synchroniser, then a machine-cycle sample and falling-edge detect.
// Assumes mc_tick is a one-cycle pulse on mclk at the machine-cycle rate.
`timescale 1ns/1ns
`default_nettype none
module mc_edge_sampler (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic mc_tick,
  input  wire logic pin,
  output logic      level,
  output logic      fall
);

  logic meta;
  logic sync;
  logic sample;
  logic next_sample;
  logic next_fall;

  always_comb begin
    next_sample = sample;
    next_fall   = 1'b0;
    if (mc_tick) begin
      next_sample = sync;
      next_fall   = sample & ~sync;
    end
  end

  // Pin synchronised before use.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta   <= 1'b0;
      sync   <= 1'b0;
      sample <= 1'b0;
      fall   <= 1'b0;
    end else begin
      meta   <= pin;
      sync   <= meta;
      sample <= next_sample;
      fall   <= next_fall;
    end
  end

  assign level = sync;

endmodule
`default_nettype wire

// File: rtl/dual_timer_counter.sv
// Two timer/counters with four modes, external gating and overflow toggle outputs.
// Assumes software drives the mode and control bits and the count writes; pins are asynchronous.
`timescale 1ns/1ns
`default_nettype none
module dual_timer_counter (
  input  wire logic                         mclk,
  input  wire logic                         reset_n,
  input  wire logic                         clock_halving_option,
  input  wire logic [7:0]                   timer_mode_reg,
  input  wire logic                         run_bit_zero,
  input  wire logic                         run_bit_one,
  input  wire logic                         toggle_out_en_zero,
  input  wire logic                         toggle_out_en_one,
  input  wire dual_timer_pkg::count_write_t write_zero,
  input  wire dual_timer_pkg::count_write_t write_one,
  input  wire logic                         clear_flag_zero,
  input  wire logic                         clear_flag_one,
  input  wire logic                         count_pin_zero,
  input  wire logic                         count_pin_one,
  input  wire logic                         gate_pin_zero,
  input  wire logic                         gate_pin_one,
  output dual_timer_pkg::count_pair_t       count_zero,
  output dual_timer_pkg::count_pair_t       count_one,
  output logic                              overflow_flag_zero,
  output logic                              overflow_flag_one,
  output logic                              baud_overflow_one,
  output logic                              toggle_pin_zero,
  output logic                              toggle_pin_one,
  output logic                              toggle_oe_zero,
  output logic                              toggle_oe_one
);

  localparam logic [3:0] MC_LAST_FAST = 4'(dual_timer_pkg::CPU_CLKS_PER_MC - 1);
  localparam logic [3:0] MC_LAST_SLOW = 4'(dual_timer_pkg::CPU_CLKS_PER_MC_SLOW - 1);

  typedef enum logic [1:0] {
    TOG_IDLE   = 2'b01,
    TOG_ACTIVE = 2'b10
  } tog_state_t;

  logic [3:0]  prescale;
  logic [3:0]  next_prescale;
  logic        mc_tick;
  logic        next_mc_tick;
  logic        fall0;
  logic        fall1;
  logic        gate0_meta;
  logic        gate0_sync;
  logic        gate1_meta;
  logic        gate1_sync;

  logic [1:0]  mode0;
  logic [1:0]  mode1;
  logic        en0;
  logic        en1;
  logic        en_split_high;
  logic        inc0;
  logic        inc1;
  logic        ovf0;
  logic        ovf1;
  logic        ovf_split_high;

  dual_timer_pkg::count_pair_t next_count_zero;
  dual_timer_pkg::count_pair_t next_count_one;
  logic        next_flag_zero;
  logic        next_flag_one;
  logic        next_baud_one;
  tog_state_t  tog0_state;
  tog_state_t  tog1_state;
  tog_state_t  next_tog0_state;
  tog_state_t  next_tog1_state;
  logic        next_toggle_zero;
  logic        next_toggle_one;

  // Machine-cycle divider: 6 clocks, or 12 with the halving option.
  // Halving option period.
  always_comb begin
    next_prescale = prescale + 4'h1;
    next_mc_tick  = 1'b0;
    if (prescale >= (clock_halving_option ? MC_LAST_SLOW : MC_LAST_FAST)) begin
      next_prescale = 4'h0;
      next_mc_tick  = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prescale <= 4'h0;
      mc_tick  <= 1'b0;
    end else begin
      prescale <= next_prescale;
      mc_tick  <= next_mc_tick;
    end
  end

  mc_edge_sampler u_sample0 (
    .mclk    (mclk),
    .reset_n (reset_n),
    .mc_tick (mc_tick),
    .pin     (count_pin_zero),
    .level   (),
    .fall    (fall0)
  );

  mc_edge_sampler u_sample1 (
    .mclk    (mclk),
    .reset_n (reset_n),
    .mc_tick (mc_tick),
    .pin     (count_pin_one),
    .level   (),
    .fall    (fall1)
  );

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      gate0_meta <= 1'b0;
      gate0_sync <= 1'b0;
      gate1_meta <= 1'b0;
      gate1_sync <= 1'b0;
    end else begin
      gate0_meta <= gate_pin_zero;
      gate0_sync <= gate0_meta;
      gate1_meta <= gate_pin_one;
      gate1_sync <= gate1_meta;
    end
  end

  assign mode0 = {timer_mode_reg[dual_timer_pkg::MODE0_HI_BIT], timer_mode_reg[dual_timer_pkg::MODE0_LO_BIT]};
  assign mode1 = {timer_mode_reg[dual_timer_pkg::MODE1_HI_BIT], timer_mode_reg[dual_timer_pkg::MODE1_LO_BIT]};

  // Split mode gives timer one's run bit to the high byte of timer zero.
  always_comb begin
    en0 = run_bit_zero & (~timer_mode_reg[dual_timer_pkg::GATE0_BIT] | gate0_sync);
    en1 = (run_bit_one | (mode0 == dual_timer_pkg::MODE_SPLIT))
          & (~timer_mode_reg[dual_timer_pkg::GATE1_BIT] | gate1_sync)
          & (mode1 != dual_timer_pkg::MODE_SPLIT);
    en_split_high = run_bit_one & (mode0 == dual_timer_pkg::MODE_SPLIT);
    inc0 = en0 & (timer_mode_reg[dual_timer_pkg::CTSEL0_BIT] ? fall0 : mc_tick);
    inc1 = en1 & (timer_mode_reg[dual_timer_pkg::CTSEL1_BIT] ? fall1 : mc_tick);
  end

  // Timer zero count path.
  always_comb begin
    next_count_zero = count_zero;
    ovf0            = 1'b0;
    ovf_split_high  = 1'b0;
    if (inc0) begin
      case (mode0)
        dual_timer_pkg::MODE_13BIT: begin
          next_count_zero.low[4:0] = count_zero.low[4:0] + 5'h1;
          if (count_zero.low[4:0] == dual_timer_pkg::LOW13_ONES) begin
            next_count_zero.high = count_zero.high + 8'h1;
            ovf0 = (count_zero.high == dual_timer_pkg::BYTE_ONES);
          end
        end
        dual_timer_pkg::MODE_16BIT: begin
          next_count_zero = count_zero + 16'h1;
          ovf0 = (count_zero == {dual_timer_pkg::BYTE_ONES, dual_timer_pkg::BYTE_ONES});
        end
        dual_timer_pkg::MODE_RELOAD: begin
          next_count_zero.low = count_zero.low + 8'h1;
          if (count_zero.low == dual_timer_pkg::BYTE_ONES) begin
            next_count_zero.low = count_zero.high;
            ovf0 = 1'b1;
          end
        end
        dual_timer_pkg::MODE_SPLIT: begin
          next_count_zero.low = count_zero.low + 8'h1;
          ovf0 = (count_zero.low == dual_timer_pkg::BYTE_ONES);
        end
        default: next_count_zero = count_zero;
      endcase
    end
    if (en_split_high && mc_tick) begin
      next_count_zero.high = count_zero.high + 8'h1;
      ovf_split_high = (count_zero.high == dual_timer_pkg::BYTE_ONES);
    end
    if (write_zero.write_high) begin
      next_count_zero.high = write_zero.data;
    end
    if (write_zero.write_low) begin
      next_count_zero.low = write_zero.data;
    end
  end

  // Timer one count path; split mode is treated as stopped.
  always_comb begin
    next_count_one = count_one;
    ovf1           = 1'b0;
    if (inc1) begin
      case (mode1)
        dual_timer_pkg::MODE_13BIT: begin
          next_count_one.low[4:0] = count_one.low[4:0] + 5'h1;
          if (count_one.low[4:0] == dual_timer_pkg::LOW13_ONES) begin
            next_count_one.high = count_one.high + 8'h1;
            ovf1 = (count_one.high == dual_timer_pkg::BYTE_ONES);
          end
        end
        dual_timer_pkg::MODE_16BIT: begin
          next_count_one = count_one + 16'h1;
          ovf1 = (count_one == {dual_timer_pkg::BYTE_ONES, dual_timer_pkg::BYTE_ONES});
        end
        dual_timer_pkg::MODE_RELOAD: begin
          next_count_one.low = count_one.low + 8'h1;
          if (count_one.low == dual_timer_pkg::BYTE_ONES) begin
            next_count_one.low = count_one.high;
            ovf1 = 1'b1;
          end
        end
        default: next_count_one = count_one;
      endcase
    end
    if (write_one.write_high) begin
      next_count_one.high = write_one.data;
    end
    if (write_one.write_low) begin
      next_count_one.low = write_one.data;
    end
  end

  // Timer one flag taken in split mode.
  always_comb begin
    next_flag_zero = ovf0 | (overflow_flag_zero & ~clear_flag_zero);
    if (mode0 == dual_timer_pkg::MODE_SPLIT) begin
      next_flag_one = ovf_split_high | (overflow_flag_one & ~clear_flag_one);
    end else begin
      next_flag_one = ovf1 | (overflow_flag_one & ~clear_flag_one);
    end
    next_baud_one = ovf1;
  end

  always_comb begin
    next_tog0_state  = tog0_state;
    next_tog1_state  = tog1_state;
    next_toggle_zero = toggle_pin_zero;
    next_toggle_one  = toggle_pin_one;
    case (tog0_state)
      TOG_IDLE: begin
        next_toggle_zero = 1'b1;
        if (toggle_out_en_zero) next_tog0_state = TOG_ACTIVE;
      end
      TOG_ACTIVE: begin
        if (!toggle_out_en_zero) begin
          next_tog0_state  = TOG_IDLE;
          next_toggle_zero = 1'b1;
        end else if (ovf0) begin
          next_toggle_zero = ~toggle_pin_zero;
        end
      end
      default: next_tog0_state = TOG_IDLE;
    endcase
    case (tog1_state)
      TOG_IDLE: begin
        next_toggle_one = 1'b1;
        if (toggle_out_en_one) next_tog1_state = TOG_ACTIVE;
      end
      TOG_ACTIVE: begin
        if (!toggle_out_en_one) begin
          next_tog1_state = TOG_IDLE;
          next_toggle_one = 1'b1;
        end else if (ovf1) begin
          next_toggle_one = ~toggle_pin_one;
        end
      end
      default: next_tog1_state = TOG_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count_zero         <= '0;
      count_one          <= '0;
      overflow_flag_zero <= 1'b0;
      overflow_flag_one  <= 1'b0;
      baud_overflow_one  <= 1'b0;
      tog0_state         <= TOG_IDLE;
      tog1_state         <= TOG_IDLE;
      toggle_pin_zero    <= 1'b1;
      toggle_pin_one     <= 1'b1;
      toggle_oe_zero     <= 1'b0;
      toggle_oe_one      <= 1'b0;
    end else begin
      count_zero         <= next_count_zero;
      count_one          <= next_count_one;
      overflow_flag_zero <= next_flag_zero;
      overflow_flag_one  <= next_flag_one;
      baud_overflow_one  <= next_baud_one;
      tog0_state         <= next_tog0_state;
      tog1_state         <= next_tog1_state;
      toggle_pin_zero    <= next_toggle_zero;
      toggle_pin_one     <= next_toggle_one;
      toggle_oe_zero     <= toggle_out_en_zero;
      toggle_oe_one      <= toggle_out_en_one;
    end
  end

endmodule
`default_nettype wire

// File: dv/dual_timer_counter_properties.sv
// Port checker for the dual timer/counter, bound into its top module.
// Assumes the single mclk domain and the hand-over timing of the design.
`timescale 1ns/1ns
`default_nettype none
module dual_timer_counter_properties (
  input wire logic                         mclk,
  input wire logic                         reset_n,
  input wire logic [7:0]                   timer_mode_reg,
  input wire logic                         run_bit_zero,
  input wire logic                         toggle_out_en_one,
  input wire dual_timer_pkg::count_write_t write_zero,
  input wire dual_timer_pkg::count_write_t write_one,
  input wire logic                         clear_flag_zero,
  input wire dual_timer_pkg::count_pair_t  count_zero,
  input wire dual_timer_pkg::count_pair_t  count_one,
  input wire logic                         overflow_flag_zero,
  input wire logic                         overflow_flag_one,
  input wire logic                         baud_overflow_one,
  input wire logic                         toggle_pin_one
);
  wire logic [1:0] mode_zero = timer_mode_reg[1:0];
  wire logic [1:0] mode_one  = timer_mode_reg[5:4];
  wire logic       load_zero = write_zero.write_high | write_zero.write_low;
  wire logic       load_one  = write_one.write_high | write_one.write_low;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence zero_idle;
    (!run_bit_zero && !load_zero && mode_zero != dual_timer_pkg::MODE_SPLIT)[*2];
  endsequence
  sequence one_parked;
    (mode_one == dual_timer_pkg::MODE_SPLIT && !load_one)[*2];
  endsequence
  a_flag_held: assert property (overflow_flag_zero && !clear_flag_zero |=> overflow_flag_zero)
    else $error("flag zero lost");
  a_flag_clear: assert property ((!run_bit_zero)[*3] ##0 clear_flag_zero |=> !overflow_flag_zero)
    else $error("flag zero not cleared");
  a_wrap_zero: assert property ($rose(overflow_flag_zero) && mode_zero == dual_timer_pkg::MODE_16BIT
    |-> count_zero == 16'h0000) else $error("flag zero without wrap");
  a_reload_low: assert property ($rose(overflow_flag_one) && mode_one == dual_timer_pkg::MODE_RELOAD
    && mode_zero != dual_timer_pkg::MODE_SPLIT |-> count_one.low == count_one.high) else $error("no reload");
  a_baud_gap: assert property (baud_overflow_one |=> (!baud_overflow_one)[*5])
    else $error("baud pulse too close");
  a_one_stopped: assert property (one_parked |=> $stable(count_one))
    else $error("timer one counts in mode three");
  a_zero_held: assert property (zero_idle |=> $stable(count_zero))
    else $error("timer zero counts while stopped");
  a_pin_idle: assert property ((!toggle_out_en_one)[*2] |-> toggle_pin_one)
    else $error("toggle pin one low while disabled");
  a_pin_flip: assert property (baud_overflow_one && $past(toggle_out_en_one)
    |-> toggle_pin_one != $past(toggle_pin_one)) else $error("toggle pin one missed overflow");
endmodule
bind dual_timer_counter dual_timer_counter_properties chk_u (.mclk, .reset_n, .timer_mode_reg, .run_bit_zero,
  .toggle_out_en_one, .write_zero, .write_one, .clear_flag_zero, .count_zero, .count_one,
  .overflow_flag_zero, .overflow_flag_one, .baud_overflow_one, .toggle_pin_one);
`default_nettype wire

// File: dv/pin_source.sv
// Far-side source of one timer's count pin and gate pin.
// Assumes pins idle high as with a pull-up; levels change at falling mclk.
`timescale 1ns/1ns
`default_nettype none
module pin_source (
  input  wire logic mclk,
  output var logic  count_level,
  output var logic  gate_level
);
  initial begin
    count_level = 1'h1;
    gate_level = 1'h1;
  end
  task automatic pulses(input int n, input int hold);
    repeat (n) begin
      repeat (hold) @(negedge mclk);
      count_level = 1'h0;
      repeat (hold) @(negedge mclk);
      count_level = 1'h1;
    end
  endtask
  task automatic set_gate(input logic level);
    @(negedge mclk);
    gate_level = level;
  endtask
endmodule
`default_nettype wire

// File: dv/dual_timer_counter_tb.sv
// Self-checking bench for the dual timer/counter with a pin source on each timer.
// Assumes the package, the design and the checker are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module dual_timer_counter_tb;
  typedef struct {
    bit          sel;
    logic [7:0]  mode_byte;
    bit          halve;
    logic [15:0] pre;
    int          k;
    logic [15:0] want;
    logic        flag;
  } row_t;
  // Timer, mode byte, halving, preload, machine cycles run, then count and flag.
  row_t rows[6] = '{
    '{1'h0, 8'h01, 1'h0, 16'hFFFE, 2, 16'h0000, 1'h1},
    '{1'h0, 8'h00, 1'h0, 16'hFF1E, 2, 16'h0000, 1'h1},
    '{1'h0, 8'h02, 1'h0, 16'h80FE, 3, 16'h8081, 1'h1},
    '{1'h0, 8'h01, 1'h1, 16'h1234, 4, 16'h1238, 1'h0},
    '{1'h1, 8'h20, 1'h0, 16'hF0FE, 3, 16'hF0F1, 1'h1},
    '{1'h1, 8'h10, 1'h0, 16'h0100, 5, 16'h0105, 1'h0}};
  logic                         mclk = 1'h0, reset_n = 1'h0, clock_halving_option = 1'h0;
  logic [7:0]                   timer_mode_reg = 8'h00;
  logic                         run_bit_zero = 1'h0, run_bit_one = 1'h0;
  logic                         toggle_out_en_zero = 1'h0, toggle_out_en_one = 1'h0;
  logic                         clear_flag_zero = 1'h0, clear_flag_one = 1'h0;
  dual_timer_pkg::count_write_t write_zero = '0, write_one = '0;
  dual_timer_pkg::count_pair_t  count_zero, count_one;
  logic                         overflow_flag_zero, overflow_flag_one, baud_overflow_one;
  logic                         toggle_pin_zero, toggle_pin_one, toggle_oe_zero, toggle_oe_one;
  wire logic                    count_pin_zero, count_pin_one, gate_pin_zero, gate_pin_one, source_zero, source_one;
  int                           n_mismatch = 0, checked = 0;

  always #4 mclk = ~mclk;
  dual_timer_counter dut_u (.mclk, .reset_n, .clock_halving_option, .timer_mode_reg, .run_bit_zero, .run_bit_one,
    .toggle_out_en_zero, .toggle_out_en_one, .write_zero, .write_one, .clear_flag_zero, .clear_flag_one,
    .count_pin_zero, .count_pin_one, .gate_pin_zero, .gate_pin_one, .count_zero, .count_one,
    .overflow_flag_zero, .overflow_flag_one, .baud_overflow_one, .toggle_pin_zero, .toggle_pin_one,
    .toggle_oe_zero, .toggle_oe_one);
  pin_source src_zero_u (.mclk, .count_level(source_zero), .gate_level(gate_pin_zero));
  pin_source src_one_u (.mclk, .count_level(source_one), .gate_level(gate_pin_one));
  // The toggle output owns the shared pin while its enable is high.
  assign count_pin_zero = toggle_oe_zero ? toggle_pin_zero : source_zero;
  assign count_pin_one = toggle_oe_one ? toggle_pin_one : source_one;

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  function automatic logic [15:0] cnt(input bit sel);
    return sel ? count_one : count_zero;
  endfunction
  function automatic logic flg(input bit sel);
    return sel ? overflow_flag_one : overflow_flag_zero;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic load(input bit sel, input logic [15:0] v);
    for (int b = 1; b >= 0; b--) begin
      @(negedge mclk);
      if (sel) write_one = {b == 1, b == 0, v[8*b +: 8]};
      else write_zero = {b == 1, b == 0, v[8*b +: 8]};
    end
    @(negedge mclk);
    write_zero = '0;
    write_one = '0;
  endtask
  task automatic pulse_clear;
    @(negedge mclk);
    clear_flag_zero = 1'h1;
    clear_flag_one = 1'h1;
    @(negedge mclk);
    clear_flag_zero = 1'h0;
    clear_flag_one = 1'h0;
  endtask
  task automatic wait_step(input bit sel);
    logic [15:0] old;
    old = cnt(sel);
    for (int i = 0; i < 30; i++) begin
      @(negedge mclk);
      if (cnt(sel) !== old) return;
    end
    n_mismatch++;
    tally_and_finish;
  endtask

  initial begin
    logic [15:0] mask;
    int mc;
    cyc(6);
    reset_n = 1'h1;
    foreach (rows[i]) begin
      mask = rows[i].mode_byte == 8'h00 ? 16'hFF1F : 16'hFFFF;
      mc = rows[i].halve ? dual_timer_pkg::CPU_CLKS_PER_MC_SLOW : dual_timer_pkg::CPU_CLKS_PER_MC;
      timer_mode_reg = rows[i].mode_byte;
      clock_halving_option = rows[i].halve;
      load(rows[i].sel, rows[i].pre);
      pulse_clear;
      if (rows[i].sel) run_bit_one = 1'h1;
      else run_bit_zero = 1'h1;
      wait_step(rows[i].sel);
      check(cnt(rows[i].sel) & mask, (rows[i].pre + 16'h0001) & mask);
      cyc((rows[i].k - 1) * mc);
      check(cnt(rows[i].sel) & mask, rows[i].want);
      check(flg(rows[i].sel), rows[i].flag);
      run_bit_zero = 1'h0;
      run_bit_one = 1'h0;
      cyc(2);
      check(flg(rows[i].sel), rows[i].flag);
      pulse_clear;
      check(flg(rows[i].sel), 1'h0);
    end
    // Event counting on pin zero, first held off by the gate, then with a slow source.
    timer_mode_reg = 8'h0D;
    load(1'h0, 16'h0000);
    run_bit_zero = 1'h1;
    src_zero_u.set_gate(1'h0);
    src_zero_u.pulses(3, 6);
    cyc(12);
    check(count_zero, 16'h0000);
    src_zero_u.set_gate(1'h1);
    src_zero_u.pulses(3, 9);
    cyc(12);
    check(count_zero, 16'h0003);
    // Split mode: timer one overflows without a flag, the high byte of timer zero owns it.
    run_bit_zero = 1'h0;
    timer_mode_reg = 8'h33;
    load(1'h0, 16'hFE10);
    load(1'h1, 16'hFFFF);
    pulse_clear;
    check(count_one, 16'hFFFF);
    run_bit_one = 1'h1;
    timer_mode_reg = 8'h13;
    wait_step(1'h1);
    check({count_one, overflow_flag_one, baud_overflow_one}, 18'h00001);
    cyc(6);
    check({count_zero, overflow_flag_one, overflow_flag_zero}, 18'h00042);
    timer_mode_reg = 8'h33;
    cyc(14);
    check(count_one, 16'h0001);
    timer_mode_reg = 8'h11;
    run_bit_one = 1'h0;
    load(1'h0, 16'hFFFF);
    load(1'h1, 16'hFFFF);
    toggle_out_en_zero = 1'h1;
    toggle_out_en_one = 1'h1;
    cyc(2);
    check({toggle_pin_zero, toggle_oe_zero, toggle_pin_one, toggle_oe_one}, 4'hF);
    run_bit_zero = 1'h1;
    run_bit_one = 1'h1;
    wait_step(1'h1);
    check({toggle_pin_zero, toggle_pin_one, baud_overflow_one}, 3'h1);
    toggle_out_en_zero = 1'h0;
    toggle_out_en_one = 1'h0;
    cyc(2);
    check({toggle_pin_zero, toggle_pin_one}, 2'h3);
    // Reset in mid-run returns every output to its idle value.
    reset_n = 1'h0;
    cyc(1);
    check({count_zero, count_one}, 32'h00000000);
    check({overflow_flag_zero, overflow_flag_one, baud_overflow_one, toggle_pin_zero, toggle_pin_one,
      toggle_oe_zero, toggle_oe_one}, 7'h0C);
    // Both timers still run, so the restarted divider shows its first tick on the seventh edge.
    reset_n = 1'h1;
    cyc(6);
    check({count_zero, count_one}, 32'h00000000);
    cyc(1);
    check({count_zero, count_one}, 32'h00010001);
    tally_and_finish;
  end
endmodule
`default_nettype wire
